// *** logic/jlt_pkg.sv ***
// constants shared by the 8b/10b lane transmitter and its character encoder
// assumes a single device clock; all timing is counted in octet cycles
package jlt_pkg;

   // link state, also shown on the state output
   typedef enum logic [1:0] {
      ST_CGS  = 2'b00,
      ST_WAIT = 2'b01,
      ST_ILAS = 2'b10,
      ST_DATA = 2'b11
   } jlt_state_e;

   // control characters, as the octet fed to the encoder with the k flag set
   localparam logic [7:0]  K28_0        = 8'h1C;
   localparam logic [7:0]  K28_3        = 8'h7C;
   localparam logic [7:0]  K28_4        = 8'h9C;
   localparam logic [7:0]  K28_5        = 8'hBC;
   localparam logic [7:0]  K28_7        = 8'hFC;
   // scrambled octets that become alignment characters
   localparam logic [7:0]  ALIGN_F_OCT  = 8'hFC;
   localparam logic [7:0]  ALIGN_A_OCT  = 8'h7C;

   // frames-per-multiframe limits: ceil(17/F) <= K <= min(256, floor(1024/F))
   localparam logic [11:0] KMIN_NUM     = 12'h011;
   localparam logic [11:0] KMAX_ABS     = 12'h100;
   localparam logic [11:0] FK_MAX       = 12'h400;
   localparam logic [1:0]  ILAS_LAST_MF = 2'h3;

   // position of configuration octets inside the second alignment multiframe
   localparam logic [11:0] CFG_POS_Q    = 12'h001;
   localparam logic [11:0] CFG_POS_F    = 12'h002;
   localparam logic [11:0] CFG_POS_K    = 12'h003;
   localparam logic [11:0] CFG_POS_SCR  = 12'h004;

   // scrambler taps, bit n mixes with output bits n-a and n-b
   localparam int          SCR8_TAP_A   = 14;
   localparam int          SCR8_TAP_B   = 15;
   localparam int          SCR64_TAP_A  = 39;
   localparam int          SCR64_TAP_B  = 58;
   localparam logic [57:0] SCR_SEED     = 58'h000_0000_0000_0000;

   // reset values after the pin filters: request line idle high, timing pulse low
   localparam logic [1:0]  PIN_RST      = 2'b01;
   localparam logic        RD_RST       = 1'b0;

endpackage : jlt_pkg

// *** logic/jlt_enc8b10b.sv ***
// 8b/10b character encoder with running disparity, one registered character per cycle
// assumes the caller only raises k for the K28.x characters listed in jlt_pkg
module jlt_enc8b10b (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       ce,
   input  wire logic [7:0] d,
   input  wire logic       k,
   output logic      [9:0] q
);

   // codes for negative running disparity, abcdei and fghj
   localparam logic [5:0] LUT6 [32] = '{
      6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
      6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
      6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
      6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
   localparam logic [3:0] LUT4 [8] = '{
      4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

   logic       rd_r;
   logic       rd_mid;
   logic       rd_out;
   logic       alt7;
   logic [4:0] x;
   logic [2:0] y;
   logic [5:0] six_raw;
   logic [5:0] six;
   logic [3:0] four_raw;
   logic [3:0] four;
   logic [9:0] kcode_raw;
   logic [9:0] code;

   assign x       = d[4:0];
   assign y       = d[7:5];
   assign six_raw = LUT6[x];
   // balanced 6b codes keep their form, except D.07 which alternates
   assign six     = (rd_r && ($countones(six_raw) != 3 || x == 5'h07)) ? ~six_raw : six_raw;
   assign rd_mid  = ($countones(six) == 3) ? rd_r : ~rd_r;
   // alternate D.x.7 avoids a run of five equal bits across the boundary
   assign alt7    = (y == 3'h7) && ((!rd_mid && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
                                    (rd_mid && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
   assign four_raw = alt7 ? 4'h7 : LUT4[y];
   assign four    = (rd_mid && ($countones(four_raw) != 2 || y == 3'h3)) ? ~four_raw : four_raw;
   assign kcode_raw = (d == jlt_pkg::K28_0) ? 10'h0F4 :
                      (d == jlt_pkg::K28_3) ? 10'h0F3 :
                      (d == jlt_pkg::K28_4) ? 10'h0F2 :
                      (d == jlt_pkg::K28_7) ? 10'h0F8 : 10'h0FA;
   assign code    = k ? (rd_r ? ~kcode_raw : kcode_raw) : {six, four};
   assign rd_out  = ($countones(code) == 5) ? rd_r : ~rd_r;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q    <= 10'h000;
         rd_r <= jlt_pkg::RD_RST;
      end else if (ce) begin
         q    <= code;
         rd_r <= rd_out;
      end
   end

endmodule : jlt_enc8b10b

// *** logic/jlt_tx_link.sv ***
// one-lane 8b/10b link transmitter: scrambler, multiframe clock, sync handshake,
// alignment sequence and alignment-character insertion
// assumes one octet per clock enable; request and timing pins are asynchronous
//
// Summary of operation
// - scrambling is optional in 8b/10b mode and always on in 64b/66b mode
// - scrambling works on raw octets before 10-bit encoding
// - the alignment sequence never passes through the scrambler
// - enable input turns scrambling on; each encoding uses its own polynomial
// - every octet becomes a DC-balanced 10-bit character tracking running disparity
// - frames per multiframe clamped between ceil(17/F) and min(256, floor(1024/F))
// - a captured timing pulse resets the multiframe counter to phase zero
// - multiframe clock period is F times K characters, ten bits each
// - while the request line is low, only K28.5 characters are sent
// - after the line rises, commas continue until the next multiframe edge
// - alignment sequence is four multiframes, each opening K28.0 and closing K28.3
// - second alignment multiframe carries the link configuration octets
// - unscrambled repeated frame-final octet becomes K28.7, or K28.3 at multiframe end
// - scrambled frame-final 0xFC sends K28.7, multiframe-final 0x7C sends K28.3
module jlt_tx_link #(
   parameter int F_W = 5,
   parameter int K_W = 9
) (
   input  wire logic           CLK_SYS,
   input  wire logic           RST_B,
   input  wire logic           CE,
   input  wire logic           SYNC_B,
   input  wire logic           SYSREF,
   input  wire logic           SCRAMBLE_ENABLE,
   input  wire logic           MODE_64B66B,
   input  wire logic [F_W-1:0] CFG_F,
   input  wire logic [K_W-1:0] CFG_K,
   input  wire logic [7:0]     TX_DATA,
   output logic                TX_READY,
   output logic      [1:0]     LINK_STATE,
   output logic      [9:0]     LANE_CHAR
);

   jlt_pkg::jlt_state_e state_r;
   jlt_pkg::jlt_state_e state_nxt;

   logic [2:0]  pin_ff [2];
   logic [1:0]  pin_in;
   logic [1:0]  pin_q;
   logic [1:0]  pin_prev_r;
   logic [11:0] lmfc_r;
   logic [11:0] lmfc_nxt;
   logic [11:0] oct_r;
   logic [11:0] oct_nxt;
   logic [1:0]  ilas_mf_r;
   logic [1:0]  ilas_mf_nxt;
   logic [57:0] scr_r;
   logic [57:0] scr_nxt;
   logic [7:0]  scr_out;
   logic [7:0]  prev_last_r;
   logic [7:0]  enc_d;
   logic        enc_k;
   logic [7:0]  ilas_oct;
   logic [11:0] f_eff;
   logic [11:0] k_eff;
   logic [11:0] k_min;
   logic [11:0] k_div;
   logic [11:0] k_max;
   logic [11:0] fk;
   logic [7:0]  data_oct;
   logic        sync_q;
   logic        sync_rise;
   logic        sysref_rise;
   logic        fr_end;
   logic        mf_end;
   logic        scr_on;
   logic        scr_step;
   logic        in_data;
   logic        same_end;
   logic        a_sub;
   logic        f_sub;

   // three-stage filter per pin; the value moves only when stages two and three agree
   assign pin_in = {SYSREF, SYNC_B};
   for (genvar i = 0; i < 2; i++) begin : g_pin
      always_ff @(posedge CLK_SYS or negedge RST_B) begin
         if (!RST_B) begin
            pin_ff[i] <= {3{jlt_pkg::PIN_RST[i]}};
            pin_q[i]  <= jlt_pkg::PIN_RST[i];
         end else if (CE) begin
            pin_ff[i] <= {pin_ff[i][1:0], pin_in[i]};
            pin_q[i]  <= (pin_ff[i][1] == pin_ff[i][2]) ? pin_ff[i][2] : pin_q[i];
         end
      end
   end

   assign sync_q      = pin_q[0];
   assign sync_rise   = pin_q[0] && !pin_prev_r[0];
   assign sysref_rise = pin_q[1] && !pin_prev_r[1];

   // configuration clamp; F of zero is taken as one
   assign f_eff = (CFG_F == '0) ? 12'h001 : 12'(CFG_F);
   assign k_min = 12'((jlt_pkg::KMIN_NUM + f_eff - 12'h001) / f_eff);
   assign k_div = 12'(jlt_pkg::FK_MAX / f_eff);
   assign k_max = (k_div > jlt_pkg::KMAX_ABS) ? jlt_pkg::KMAX_ABS : k_div;
   assign k_eff = (12'(CFG_K) < k_min) ? k_min :
                  (12'(CFG_K) > k_max) ? k_max : 12'(CFG_K);
   assign fk    = 12'(f_eff * k_eff);

   assign fr_end = (oct_r == f_eff - 12'h001);
   assign mf_end = (lmfc_r == fk - 12'h001);
   // a pulse restarts both counters at phase zero, whatever the link state
   assign lmfc_nxt = (sysref_rise || mf_end) ? 12'h000 : lmfc_r + 12'h001;
   assign oct_nxt  = (sysref_rise || mf_end || fr_end) ? 12'h000 : oct_r + 12'h001;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         jlt_pkg::ST_CGS:  if (sync_rise) state_nxt = jlt_pkg::ST_WAIT;
         jlt_pkg::ST_WAIT: if (mf_end) state_nxt = jlt_pkg::ST_ILAS;
         jlt_pkg::ST_ILAS: if (mf_end && ilas_mf_r == jlt_pkg::ILAS_LAST_MF) begin
            state_nxt = jlt_pkg::ST_DATA;
         end
         default: ;
      endcase
      if (!sync_q) begin
         state_nxt = jlt_pkg::ST_CGS;
      end
   end

   assign ilas_mf_nxt = (state_r != jlt_pkg::ST_ILAS) ? 2'h0 :
                        mf_end ? ilas_mf_r + 2'h1 : ilas_mf_r;

   // bit-serial self-synchronous scrambler, first octet bit is the msb
   function automatic logic [65:0] scr_fn(input logic [57:0] st, input logic [7:0] d,
                                          input logic wide);
      logic [57:0] s;
      logic [7:0]  o;
      s = st;
      o = 8'h00;
      for (int b = 7; b >= 0; b--) begin
         o[b] = d[b] ^ (wide ? s[jlt_pkg::SCR64_TAP_A-1] : s[jlt_pkg::SCR8_TAP_A-1])
                     ^ (wide ? s[jlt_pkg::SCR64_TAP_B-1] : s[jlt_pkg::SCR8_TAP_B-1]);
         s    = {s[56:0], o[b]};
      end
      return {s, o};
   endfunction : scr_fn

   assign scr_on   = SCRAMBLE_ENABLE || MODE_64B66B;
   assign {scr_nxt, scr_out} = scr_fn(scr_r, TX_DATA, MODE_64B66B);
   // the scrambler only steps on user data, so the alignment sequence never moves it
   assign scr_step = CE && scr_on && (state_r == jlt_pkg::ST_DATA);
   assign data_oct = scr_on ? scr_out : TX_DATA;

   // alignment-character substitution at frame and multiframe ends
   assign in_data  = (state_r == jlt_pkg::ST_DATA);
   assign same_end = fr_end && (data_oct == prev_last_r);
   assign a_sub    = in_data && mf_end &&
                     (scr_on ? (data_oct == jlt_pkg::ALIGN_A_OCT) : same_end);
   assign f_sub    = in_data && fr_end && !a_sub &&
                     (scr_on ? (data_oct == jlt_pkg::ALIGN_F_OCT) : same_end);

   // alignment multiframe content: ramp, with configuration in the second one
   assign ilas_oct = (ilas_mf_r != 2'h1)          ? lmfc_r[7:0] :
                     (lmfc_r == jlt_pkg::CFG_POS_F)   ? 8'(f_eff - 12'h001) :
                     (lmfc_r == jlt_pkg::CFG_POS_K)   ? 8'(k_eff - 12'h001) :
                     (lmfc_r == jlt_pkg::CFG_POS_SCR) ? {scr_on, 7'h00} : 8'h00;

   always_comb begin
      enc_k = 1'b1;
      enc_d = jlt_pkg::K28_5;
      case (state_r)
         jlt_pkg::ST_ILAS: begin
            if (lmfc_r == 12'h000) begin
               enc_d = jlt_pkg::K28_0;
            end else if (mf_end) begin
               enc_d = jlt_pkg::K28_3;
            end else if (ilas_mf_r == 2'h1 && lmfc_r == jlt_pkg::CFG_POS_Q) begin
               enc_d = jlt_pkg::K28_4;
            end else begin
               enc_k = 1'b0;
               enc_d = ilas_oct;
            end
         end
         jlt_pkg::ST_DATA: begin
            enc_k = a_sub || f_sub;
            enc_d = a_sub ? jlt_pkg::K28_3 : f_sub ? jlt_pkg::K28_7 : data_oct;
         end
         default: ;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         state_r     <= jlt_pkg::ST_CGS;
         pin_prev_r  <= jlt_pkg::PIN_RST;
         lmfc_r      <= 12'h000;
         oct_r       <= 12'h000;
         ilas_mf_r   <= 2'h0;
         prev_last_r <= 8'h00;
         TX_READY    <= 1'b0;
         LINK_STATE  <= jlt_pkg::ST_CGS;
      end else if (CE) begin
         state_r     <= state_nxt;
         pin_prev_r  <= pin_q;
         lmfc_r      <= lmfc_nxt;
         oct_r       <= oct_nxt;
         ilas_mf_r   <= ilas_mf_nxt;
         prev_last_r <= (in_data && fr_end) ? data_oct : prev_last_r;
         TX_READY    <= (state_nxt == jlt_pkg::ST_DATA);
         LINK_STATE  <= state_nxt;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         scr_r <= jlt_pkg::SCR_SEED;
      end else if (scr_step) begin
         scr_r <= scr_nxt;
      end
   end

   jlt_enc8b10b u_enc (
      .clk   (CLK_SYS),
      .rst_b (RST_B),
      .ce    (CE),
      .d     (enc_d),
      .k     (enc_k),
      .q     (LANE_CHAR)
   );

   // checks
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_B);

   property p_cgs_comma;
      (state_r == jlt_pkg::ST_CGS) |-> enc_k && enc_d == jlt_pkg::K28_5;
   endproperty
   a_cgs_comma: assert property (p_cgs_comma) else $error("no comma in sync");

   property p_sysref_phase;
      (CE && sysref_rise) |=> (lmfc_r == 12'h000 && oct_r == 12'h000);
   endproperty
   a_sysref_phase: assert property (p_sysref_phase) else $error("lmfc not reset");

   property p_wait_holds;
      (CE && state_r == jlt_pkg::ST_WAIT && !mf_end && sync_q) |=> state_r == jlt_pkg::ST_WAIT;
   endproperty
   a_wait_holds: assert property (p_wait_holds) else $error("ilas before lmfc edge");

   property p_wait_go;
      (CE && state_r == jlt_pkg::ST_WAIT && mf_end && sync_q && !sysref_rise)
         |=> state_r == jlt_pkg::ST_ILAS && lmfc_r == 12'h000 && enc_d == jlt_pkg::K28_0;
   endproperty
   a_wait_go: assert property (p_wait_go) else $error("ilas not started");

   property p_ilas_frame;
      (state_r == jlt_pkg::ST_ILAS && mf_end) |-> enc_k && enc_d == jlt_pkg::K28_3;
   endproperty
   a_ilas_frame: assert property (p_ilas_frame) else $error("ilas end char wrong");

   property p_ilas_noscr;
      (CE && state_r == jlt_pkg::ST_ILAS) |=> $stable(scr_r);
   endproperty
   a_ilas_noscr: assert property (p_ilas_noscr) else $error("scrambler moved in ilas");

   property p_repeat_f;
      (in_data && !scr_on && fr_end && !mf_end && data_oct == prev_last_r)
         |-> enc_k && enc_d == jlt_pkg::K28_7;
   endproperty
   a_repeat_f: assert property (p_repeat_f) else $error("missing K28.7");

   property p_scr_a;
      (in_data && scr_on && mf_end && data_oct == jlt_pkg::ALIGN_A_OCT)
         |-> enc_k && enc_d == jlt_pkg::K28_3;
   endproperty
   a_scr_a: assert property (p_scr_a) else $error("missing K28.3");

   property p_k_range;
      k_eff >= k_min && k_eff <= k_max && lmfc_r < fk;
   endproperty
   a_k_range: assert property (p_k_range) else $error("K out of range");

   property p_data_start;
      (CE && state_r == jlt_pkg::ST_ILAS && mf_end && ilas_mf_r == 2'h3 && sync_q)
         |=> TX_READY && state_r == jlt_pkg::ST_DATA;
   endproperty
   a_data_start: assert property (p_data_start) else $error("data not started");

   c_ilas: cover property (state_r == jlt_pkg::ST_ILAS && ilas_mf_r == 2'h1);
   c_data: cover property (state_r == jlt_pkg::ST_DATA);
   c_fsub: cover property (f_sub);
   c_sysref: cover property (CE && sysref_rise && state_r == jlt_pkg::ST_DATA);

endmodule : jlt_tx_link

// *** test/jlt_rx_partner.sv ***
// receiver-side model: multiframe clock, comma lock and the sync request line
// assumes lane characters arrive already word-aligned, one per enabled clock edge
module jlt_rx_partner (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        ce,
   input  wire logic        sysref,
   input  wire logic        req,
   input  wire logic        slow,
   input  wire logic [11:0] fk,
   input  wire logic [9:0]  lane_char,
   output logic             sync_b,
   output logic      [11:0] lmfc
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [4:0] sr_h;
   logic [2:0] comma_cnt;
   logic       extra;
   // both disparities of the comma count as a lock character
   wire        comma   = (lane_char == 10'h0FA) || (lane_char == 10'h305);
   wire        mf_edge = (lmfc == fk - 12'h001);

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sr_h      <= 5'h00;
         lmfc      <= 12'h000;
         sync_b    <= 1'b1;
         comma_cnt <= 3'h0;
         extra     <= 1'b0;
      end else begin
         if (ce) begin
            // three filter stages, the filtered value and the edge register, as in the transmitter,
            // so both counters restart on the same enabled edge
            sr_h <= {sr_h[3:0], sysref};
            lmfc <= ((sr_h[3] && !sr_h[4]) || mf_edge) ? 12'h000 : lmfc + 12'h001;
            if (!sync_b) begin
               comma_cnt <= !comma ? 3'h0 : (comma_cnt == 3'h4) ? comma_cnt : comma_cnt + 3'h1;
               if (comma_cnt == 3'h4 && mf_edge) begin
                  extra <= ~extra;
                  // slow receiver lets one more multiframe pass before releasing
                  if (!slow || extra) sync_b <= 1'b1;
               end
            end
         end
         if (req) begin
            sync_b    <= 1'b0;
            comma_cnt <= 3'h0;
            extra     <= 1'b0;
         end
      end
   end
endmodule : jlt_rx_partner

// *** test/jlt_tx_link_test.sv ***
// self-checking bench for the one-lane link transmitter
// assumes the receiver model shares the device clock and sees every lane character
`define CHK(nm, e, g) begin compares++; if ((e) !== (g)) begin mismatches++; $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module jlt_tx_link_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic        CLK_SYS, RST_B, CE, SYNC_B, SYSREF, SCRAMBLE_ENABLE, MODE_64B66B;
   logic [4:0]  CFG_F;
   logic [8:0]  CFG_K;
   logic [7:0]  TX_DATA, prev_fin, oct;
   logic        TX_READY, req, slow, scr_on, m64, pend, pvalid, fin;
   logic [1:0]  LINK_STATE;
   logic [9:0]  LANE_CHAR;
   logic [11:0] lmfc, fk, pos;
   logic [57:0] hist;
   logic [3:0]  exp_code;
   int          mismatches, compares, f_e, icnt, cum;

   jlt_tx_link i_dut (
      .CLK_SYS(CLK_SYS), .RST_B(RST_B), .CE(CE), .SYNC_B(SYNC_B), .SYSREF(SYSREF),
      .SCRAMBLE_ENABLE(SCRAMBLE_ENABLE), .MODE_64B66B(MODE_64B66B), .CFG_F(CFG_F),
      .CFG_K(CFG_K), .TX_DATA(TX_DATA), .TX_READY(TX_READY), .LINK_STATE(LINK_STATE),
      .LANE_CHAR(LANE_CHAR));

   jlt_rx_partner i_rx (
      .clk(CLK_SYS), .rst_b(RST_B), .ce(CE), .sysref(SYSREF), .req(req), .slow(slow),
      .fk(fk), .lane_char(LANE_CHAR), .sync_b(SYNC_B), .lmfc(lmfc));

   // K28.x identity from the character, disparity folded out; F means not a K28 character
   function automatic logic [3:0] k28_code(input logic [9:0] c);
      if (c[9:4] == 6'h0F) return c[3:0];
      if (c[9:4] == 6'h30) return ~c[3:0];
      return 4'hF;
   endfunction : k28_code

   // bit-serial msb first; fwd scrambles and advances, else finds the input giving v
   function automatic logic [7:0] scramble_enable(input logic [7:0] v, input logic fwd);
      logic [57:0] h;
      logic [7:0]  o;
      h = hist;
      for (int i = 7; i >= 0; i--) begin
         o[i] = v[i] ^ (m64 ? h[jlt_pkg::SCR64_TAP_A-1] ^ h[jlt_pkg::SCR64_TAP_B-1]
                            : h[jlt_pkg::SCR8_TAP_A-1] ^ h[jlt_pkg::SCR8_TAP_B-1]);
         h = {h[56:0], fwd ? o[i] : v[i]};
      end
      if (fwd) hist = h;
      return o;
   endfunction : scramble_enable

   task automatic results();
      if (mismatches == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : results

   // inputs change only at the falling edge; one frame end in three, at random, gets an alignment-prone octet
   task automatic tick(input bit ce_rand);
      logic [7:0] t;
      @(negedge CLK_SYS);
      CE = ce_rand ? ($urandom % 8 != 0) : 1'b1;
      t = 8'($urandom);
      if ((lmfc % f_e) == f_e - 1 && $urandom % 3 == 0) begin
         case ($urandom % 3)
            0: t = 8'hFC;
            1: t = 8'h7C;
            default: t = prev_fin;
         endcase
      end
      TX_DATA = scr_on ? scramble_enable(t, 1'b0) : t;
   endtask : tick

   task automatic wait_st(input logic [1:0] s, input int lim);
      int n;
      n = 0;
      while (LINK_STATE !== s && n < lim) begin
         tick(1'b1);
         n++;
      end
      `CHK("link_state", s, LINK_STATE)
   endtask : wait_st

   task automatic phase(input int f, input int k, input logic sc, input logic m,
                        input bit abort, input logic sl);
      int kk;
      f_e = (f == 0) ? 1 : f;
      kk = (k < (16 + f_e) / f_e) ? (16 + f_e) / f_e : k;
      if (kk > 256) kk = 256;
      if (kk > 1024 / f_e) kk = 1024 / f_e;
      fk = 12'(f_e * kk);
      scr_on = sc | m;
      m64 = m;
      tick(1'b0);
      RST_B = 1'b0;
      CFG_F = 5'(f);
      CFG_K = 9'(k);
      SCRAMBLE_ENABLE = sc;
      MODE_64B66B = m;
      slow = sl;
      repeat (10) tick(1'b0);
      RST_B = 1'b1;
      repeat (5) tick(1'b1);
      SYSREF = 1'b1;
      repeat (8) tick(1'b0);
      SYSREF = 1'b0;
      repeat (8) tick(1'b1);
      req = 1'b1;
      tick(1'b1);
      req = 1'b0;
      wait_st(jlt_pkg::ST_DATA, 10 * f_e * kk + 300);
      repeat (600) tick(1'b1);
      // pulses at the multiframe rate land on the lmfc edge and must not disturb data
      repeat (2) begin
         while (lmfc != fk - 12'h005) tick(1'b1);
         SYSREF = 1'b1;
         repeat (8) tick(1'b0);
         SYSREF = 1'b0;
      end
      wait_st(jlt_pkg::ST_DATA, 1);
      if (abort) begin
         // receiver drops the line mid-stream: link falls back to commas
         req = 1'b1;
         tick(1'b1);
         req = 1'b0;
         wait_st(jlt_pkg::ST_CGS, 40);
         wait_st(jlt_pkg::ST_DATA, 10 * f_e * kk + 300);
         repeat (300) tick(1'b1);
      end
   endtask : phase

   initial begin
      CLK_SYS = 1'b0;
      forever #5 CLK_SYS = ~CLK_SYS;
   end

   // character monitor: each enabled edge decides the character seen at the next edge
   always @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         pend = 1'b0;
         cum = 0;
         icnt = 0;
         pvalid = 1'b0;
         hist = '0;
      end else begin
         if (pend) begin
            if (exp_code !== 4'hE) `CHK("char", exp_code, k28_code(LANE_CHAR))
            cum = cum + $countones(LANE_CHAR) - 5;
            `CHK("balance", 1'b1, (cum == 0 || cum == 1))
         end
         pend = CE;
         if (CE) begin
            `CHK("ready", (LINK_STATE == jlt_pkg::ST_DATA), TX_READY)
            exp_code = 4'hA;
            if (LINK_STATE == jlt_pkg::ST_ILAS) begin
               if (icnt == 0) `CHK("ilas_phase", 12'h000, lmfc)
               pos = 12'(icnt % fk);
               // never scrambled: markers sit at fixed places whatever the setting
               exp_code = (pos == 0) ? 4'h4 : (pos == fk - 1) ? 4'h3 :
                          (icnt / fk == 1 && pos == 1) ? 4'h2 : 4'hF;
               icnt++;
            end else if (LINK_STATE == jlt_pkg::ST_DATA) begin
               if (icnt != 0) begin
                  `CHK("ilas_len", 4 * fk, icnt)
                  `CHK("data_phase", 12'h000, lmfc)
                  icnt = 0;
                  pvalid = 1'b0;
               end
               fin = (lmfc % f_e) == f_e - 1;
               oct = scr_on ? scramble_enable(TX_DATA, 1'b1) : TX_DATA;
               exp_code = 4'hF;
               if (fin && scr_on)
                  exp_code = (lmfc == fk - 1 && oct == 8'h7C) ? 4'h3 :
                             (oct == 8'hFC) ? 4'h8 : 4'hF;
               else if (fin && !pvalid) exp_code = 4'hE;
               else if (fin && oct == prev_fin) exp_code = (lmfc == fk - 1) ? 4'h3 : 4'h8;
               if (fin) begin
                  prev_fin = oct;
                  pvalid = 1'b1;
               end
            end else icnt = 0;
         end
      end
   end

   initial begin
      mismatches = 0;
      compares = 0;
      RST_B = 1'b0;
      CE = 1'b0;
      SYSREF = 1'b0;
      req = 1'b0;
      slow = 1'b0;
      TX_DATA = 8'h00;
      CFG_F = 5'h01;
      CFG_K = 9'h014;
      SCRAMBLE_ENABLE = 1'b0;
      MODE_64B66B = 1'b0;
      f_e = 1;
      fk = 12'h014;
      scr_on = 1'b0;
      m64 = 1'b0;
      prev_fin = 8'h00;
      exp_code = 4'hE;
      void'($urandom(29));
      phase(1, 20, 1'b0, 1'b0, 1'b1, 1'b0);
      phase(4, 2, 1'b1, 1'b0, 1'b0, 1'b1);
      phase(8, 300, 1'b0, 1'b1, 1'b0, 1'b0);
      phase(0, 1, 1'b1, 1'b0, 1'b0, 1'b1);
      phase(31, 40, 1'b0, 1'b0, 1'b0, 1'b0);
      results();
   end

   // a hang ends the run well past the longest expected link-up sequence
   initial begin
      #800_000;
      mismatches++;
      results();
   end
endmodule : jlt_tx_link_test
